// >>> rtl/ptpse_core.sv
`timescale 1ns/1ps
// Operation
// - The servo state reads as not ready, synchronizing, locked or inapplicable.
// - The master identity is the hardware address with 0xfffe placed between its upper and lower halves.
// - The 64-bit offset to the master in nanoseconds is always readable.
// - The measured offset drives the correction applied to the local clock while following a master.
// - The last port change event is kept as one of sixteen codes.
// - An offset beyond the step limit drops the lock and starts offset adjustment.
// - Software picks the step limit among 10, 20, 100, 500, 1000 and 2000 microseconds.
// - A periodic event fires a programmable number of 32 ns steps after the current tick.
// - An interval of zero stops the periodic event generator.
// - Each periodic event lands within 80 ns of its intended time.
// - The transport of the time messages is readable.
// - As time master, a written reference time in nanoseconds becomes the clock's time.
// - Periodic events wait until the time counter has passed a software start value.
module ptpse_core #(
   parameter int NS_PER_CYCLE = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [47:0] master_hw_address,
   input wire logic offset_valid,
   input wire logic [63:0] master_offset_nanoseconds,
   input wire logic port_event_valid,
   input wire logic [3:0] port_event_code,
   input wire logic [1:0] time_message_transport,
   output logic [63:0] local_time,
   output logic [31:0] clock_correction,
   output logic periodic_event,
   output logic irq
);
   import ptpse_pkg::*;

   typedef struct packed {
      logic [31:0] control;
      logic [IRQ_WIDTH-1:0] irq_status;
      logic [IRQ_WIDTH-1:0] irq_mask;
      logic [31:0] interval;
      logic [63:0] offset;
      logic [63:0] identity;
      logic [3:0] last_event;
      ptpse_servo_type servo;
      logic [63:0] time_now;
      logic [63:0] next_event_time;
      logic started;
      logic [31:0] correction;
      logic event_pulse;
      logic rd_store;
      logic [31:0] rdata;
   } ptpse_state_type;

   ptpse_state_type cur;
   ptpse_state_type nxt;

   logic access_phase;
   logic wr;
   logic store_we;
   logic [1:0] store_widx;
   logic [1:0] store_ridx;
   logic [31:0] store_rdata;
   logic [127:0] store_words;
   logic [63:0] begin_time;
   logic [63:0] ref_time;
   logic [63:0] abs_offset;
   logic [63:0] limit_ns;
   logic [63:0] interval_ns;
   logic mapped;

   // Microsecond limit to nanoseconds for a selection code.
   function automatic logic [63:0] ptpse_limit_ns(input logic [2:0] sel);
      int us;
      case (sel)
         3'h0: us = LIMIT_US_0;
         3'h1: us = LIMIT_US_1;
         3'h2: us = LIMIT_US_2;
         3'h3: us = LIMIT_US_3;
         3'h4: us = LIMIT_US_4;
         default: us = LIMIT_US_5;
      endcase
      return 64'(us) * 64'd1000;
   endfunction

   // Magnitude of a signed 64-bit offset.
   function automatic logic [63:0] ptpse_abs(input logic [63:0] v);
      return v[63] ? (~v + 64'd1) : v;
   endfunction

   // Register access is a single-cycle answer with no wait states.
   assign access_phase = psel && penable;
   assign wr = access_phase && pwrite;
   assign pready = 1'b1;
   assign prdata = cur.rd_store ? store_rdata : cur.rdata;

   // Software 64-bit values live in the store: begin time in words 0-1, reference time in 2-3.
   always_comb begin
      store_we = wr && (paddr == OFS_BEGIN_LO || paddr == OFS_BEGIN_HI ||
                        paddr == OFS_REFTIME_LO || paddr == OFS_REFTIME_HI);
      store_widx = paddr[3:2];
      store_ridx = paddr[3:2];
   end

   ptpse_time_store #(
      .WORDS(4)
   ) u_store (
      .pclk(pclk),
      .presetn(presetn),
      .write_enable(store_we),
      .write_index(store_widx),
      .write_data(pwdata),
      .read_index(store_ridx),
      .read_data(store_rdata),
      .all_words(store_words)
   );

   assign begin_time = store_words[63:0];
   assign ref_time = store_words[127:64];
   assign abs_offset = ptpse_abs(cur.offset);
   assign limit_ns = ptpse_limit_ns(cur.control[CTL_LIMIT_LSB +: 3]);
   assign interval_ns = 64'(cur.interval) * 64'(INTERVAL_STEP_NS);

   // Address decode; anything outside the map answers with an error.
   always_comb begin
      case (paddr)
         OFS_CONTROL, OFS_STATUS, OFS_IRQ_STATUS, OFS_IRQ_MASK, OFS_MAC_LO, OFS_MAC_HI,
         OFS_IDENT_LO, OFS_IDENT_HI, OFS_OFFSET_LO, OFS_OFFSET_HI, OFS_EVENT, OFS_INTERVAL,
         OFS_BEGIN_LO, OFS_BEGIN_HI, OFS_REFTIME_LO, OFS_REFTIME_HI, OFS_TIME_LO,
         OFS_TIME_HI, OFS_CORRECTION: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = access_phase && !mapped;

   // Next-state logic for the whole block.
   always_comb begin
      logic [IRQ_WIDTH-1:0] set_bits;
      logic [IRQ_WIDTH-1:0] clr_bits;
      logic over_limit;
      set_bits = '0;
      clr_bits = '0;
      over_limit = 1'b0;
      nxt = cur;
      nxt.event_pulse = 1'b0;
      nxt.rd_store = 1'b0;
      nxt.rdata = 32'h0000_0000;

      // Identity is rebuilt every cycle so a new master address shows one cycle later.
      nxt.identity = {master_hw_address[47:24], IDENT_FILL, master_hw_address[23:0]};

      // Latest offset sample is kept for reading.
      if (offset_valid) begin
         nxt.offset = master_offset_nanoseconds;
      end

      // Last port change event, kept until the next one arrives.
      if (port_event_valid) begin
         nxt.last_event = port_event_code;
         set_bits[IRQ_PORT_EVENT_BIT] = 1'b1;
      end

      // Servo: an oversize offset always unlocks; a small one relocks.
      over_limit = ptpse_abs(master_offset_nanoseconds) > limit_ns;
      if (offset_valid) begin
         case (cur.servo)
            ptpse_idle: begin
               nxt.servo = over_limit ? ptpse_sync : ptpse_lock;
               if (!over_limit) begin
                  set_bits[IRQ_LOCK_BIT] = 1'b1;
               end
            end
            ptpse_sync: begin
               if (!over_limit) begin
                  nxt.servo = ptpse_lock;
                  set_bits[IRQ_LOCK_BIT] = 1'b1;
               end
            end
            ptpse_lock: begin
               if (over_limit) begin
                  nxt.servo = ptpse_sync;
                  set_bits[IRQ_UNLOCK_BIT] = 1'b1;
               end
            end
            default: nxt.servo = ptpse_idle;
         endcase
      end

      // Offset becomes the correction while following; the step is a coarse proportional term.
      if (offset_valid && !cur.control[CTL_MASTER_BIT]) begin
         nxt.correction = master_offset_nanoseconds[31:0];
      end

      // Local time runs every cycle; in sync state while following, each offset sample, whatever its size, is stepped out at once.
      nxt.time_now = cur.time_now + 64'(NS_PER_CYCLE);
      if (offset_valid && !cur.control[CTL_MASTER_BIT] && cur.servo == ptpse_sync) begin
         nxt.time_now = cur.time_now + 64'(NS_PER_CYCLE) - master_offset_nanoseconds;
      end

      // Start gate and periodic event generator.
      if (cur.interval == 32'h0000_0000) begin
         nxt.started = 1'b0;
      end else if (!cur.started) begin
         if (cur.time_now > begin_time) begin
            nxt.started = 1'b1;
            nxt.next_event_time = cur.time_now + interval_ns;
         end
      end else if (cur.time_now >= cur.next_event_time) begin
         // Checked every 5 ns cycle, so lateness stays well under the accuracy bound.
         nxt.event_pulse = 1'b1;
         nxt.next_event_time = cur.next_event_time + interval_ns;
         set_bits[IRQ_PERIODIC_BIT] = 1'b1;
      end

      // Register writes.
      if (wr) begin
         case (paddr)
            OFS_CONTROL: nxt.control = pwdata;
            OFS_IRQ_STATUS: clr_bits = pwdata[IRQ_WIDTH-1:0];
            OFS_IRQ_MASK: nxt.irq_mask = pwdata[IRQ_WIDTH-1:0];
            OFS_INTERVAL: begin
               nxt.interval = pwdata;
               nxt.started = 1'b0;
            end
            OFS_REFTIME_HI: begin
               if (cur.control[CTL_MASTER_BIT]) begin
                  // Upper word completes the reference; low word was stored a write earlier.
                  nxt.time_now = {pwdata, ref_time[31:0]};
               end
            end
            default: ;
         endcase
      end

      // Set beats clear in the same cycle.
      nxt.irq_status = (cur.irq_status & ~clr_bits) | set_bits;

      // Register reads are captured in the setup cycle for the access-phase answer.
      if (psel && !penable && !pwrite) begin
         case (paddr)
            OFS_CONTROL: nxt.rdata = cur.control;
            OFS_STATUS: begin
               // Servo state code with the transport in bits 9:8.
               case (cur.servo)
                  ptpse_sync: nxt.rdata[1:0] = SERVO_SYNCHRONIZING;
                  ptpse_lock: nxt.rdata[1:0] = SERVO_LOCKED;
                  default: nxt.rdata[1:0] = SERVO_NOT_READY;
               endcase
               if (!cur.control[CTL_APPLICABLE_BIT]) begin
                  nxt.rdata[1:0] = servo_state_inapplicable;
               end
               nxt.rdata[CTL_TRANSPORT_LSB +: 2] = time_message_transport;
               nxt.rdata[2] = cur.started;
            end
            OFS_IRQ_STATUS: nxt.rdata[IRQ_WIDTH-1:0] = cur.irq_status;
            OFS_IRQ_MASK: nxt.rdata[IRQ_WIDTH-1:0] = cur.irq_mask;
            OFS_MAC_LO: nxt.rdata = master_hw_address[31:0];
            OFS_MAC_HI: nxt.rdata[15:0] = master_hw_address[47:32];
            OFS_IDENT_LO: nxt.rdata = cur.identity[31:0];
            OFS_IDENT_HI: nxt.rdata = cur.identity[63:32];
            OFS_OFFSET_LO: nxt.rdata = cur.offset[31:0];
            OFS_OFFSET_HI: nxt.rdata = cur.offset[63:32];
            OFS_EVENT: nxt.rdata[3:0] = cur.last_event;
            OFS_INTERVAL: nxt.rdata = cur.interval;
            OFS_BEGIN_LO, OFS_BEGIN_HI, OFS_REFTIME_LO, OFS_REFTIME_HI: nxt.rd_store = 1'b1;
            OFS_TIME_LO: nxt.rdata = cur.time_now[31:0];
            OFS_TIME_HI: nxt.rdata = cur.time_now[63:32];
            OFS_CORRECTION: nxt.rdata = cur.correction;
            default: nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   // One register process for all state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '{control: CTL_RESET, servo: ptpse_idle, last_event: EV_NONE, default: '0};
      end else begin
         cur <= nxt;
      end
   end

   assign local_time = cur.time_now;
   assign clock_correction = cur.correction;
   assign periodic_event = cur.event_pulse;
   assign irq = |(cur.irq_status & cur.irq_mask);
endmodule

// >>> rtl/ptpse_pkg.sv
package ptpse_pkg;
   // Register byte offsets on the APB word map.
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFS_MAC_LO = 8'h10;
   localparam logic [7:0] OFS_MAC_HI = 8'h14;
   localparam logic [7:0] OFS_IDENT_LO = 8'h18;
   localparam logic [7:0] OFS_IDENT_HI = 8'h1c;
   localparam logic [7:0] OFS_OFFSET_LO = 8'h20;
   localparam logic [7:0] OFS_OFFSET_HI = 8'h24;
   localparam logic [7:0] OFS_EVENT = 8'h28;
   localparam logic [7:0] OFS_INTERVAL = 8'h2c;
   localparam logic [7:0] OFS_BEGIN_LO = 8'h30;
   localparam logic [7:0] OFS_BEGIN_HI = 8'h34;
   localparam logic [7:0] OFS_REFTIME_LO = 8'h38;
   localparam logic [7:0] OFS_REFTIME_HI = 8'h3c;
   localparam logic [7:0] OFS_TIME_LO = 8'h40;
   localparam logic [7:0] OFS_TIME_HI = 8'h44;
   localparam logic [7:0] OFS_CORRECTION = 8'h48;

   // Control register fields.
   localparam int CTL_LIMIT_LSB = 0;
   localparam int CTL_APPLICABLE_BIT = 4;
   localparam int CTL_MASTER_BIT = 5;
   localparam int CTL_TRANSPORT_LSB = 8;
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;

   // Interrupt status bit positions.
   localparam int IRQ_UNLOCK_BIT = 0;
   localparam int IRQ_LOCK_BIT = 1;
   localparam int IRQ_PERIODIC_BIT = 2;
   localparam int IRQ_PORT_EVENT_BIT = 3;
   localparam int IRQ_WIDTH = 4;

   // Value inserted in the middle of the hardware address.
   localparam logic [15:0] IDENT_FILL = 16'hfffe;

   // Servo states as reported to software.
   localparam logic [1:0] SERVO_NOT_READY = 2'h0;
   localparam logic [1:0] SERVO_SYNCHRONIZING = 2'h1;
   localparam logic [1:0] SERVO_LOCKED = 2'h2;
   localparam logic [1:0] servo_state_inapplicable = 2'h3;

   // Port change event codes.
   localparam logic [3:0] EV_NONE = 4'h0;
   localparam logic [3:0] EV_POWER_UP = 4'h1;
   localparam logic [3:0] EV_INITIALIZE = 4'h2;
   localparam logic [3:0] port_enabled_event = 4'h3;
   localparam logic [3:0] port_disabled_event = 4'h4;
   localparam logic [3:0] EV_FAULT_CLEARED = 4'h5;
   localparam logic [3:0] EV_FAULT_DETECTED = 4'h6;
   localparam logic [3:0] EV_STATE_DECISION = 4'h7;
   localparam logic [3:0] EV_QUAL_TIMEOUT = 4'h8;
   localparam logic [3:0] EV_ANNOUNCE_TIMEOUT = 4'h9;
   localparam logic [3:0] EV_SYNC_FAULT = 4'ha;
   localparam logic [3:0] EV_MASTER_SELECTED = 4'hb;
   localparam logic [3:0] recommend_master_event = 4'hc;
   localparam logic [3:0] recommend_top_master_event = 4'hd;
   localparam logic [3:0] recommend_follower_event = 4'he;
   localparam logic [3:0] recommend_idle_event = 4'hf;

   // Step limit selections in microseconds and the clock rate.
   localparam int LIMIT_US_0 = 10;
   localparam int LIMIT_US_1 = 20;
   localparam int LIMIT_US_2 = 100;
   localparam int LIMIT_US_3 = 500;
   localparam int LIMIT_US_4 = 1000;
   localparam int LIMIT_US_5 = 2000;
   localparam int CLOCK_PERIOD_NS = 5;
   localparam int INTERVAL_STEP_NS = 32;
   localparam int EVENT_ACCURACY_NS = 80;
   // Worst-case lateness of an event in clock cycles, rounded down.
   localparam int EVENT_ACCURACY_CYCLES = EVENT_ACCURACY_NS / CLOCK_PERIOD_NS;

   // Servo state machine, one-hot.
   typedef enum logic [2:0] {
      ptpse_idle = 3'b001,
      ptpse_sync = 3'b010,
      ptpse_lock = 3'b100
   } ptpse_servo_type;
endpackage

// >>> rtl/ptpse_time_store.sv
`timescale 1ns/1ps
// Small register bank holding 64-bit software values as pairs of words.
module ptpse_time_store #(
   parameter int WORDS = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic write_enable,
   input wire logic [$clog2(WORDS)-1:0] write_index,
   input wire logic [31:0] write_data,
   input wire logic [$clog2(WORDS)-1:0] read_index,
   output logic [31:0] read_data,
   output logic [WORDS*32-1:0] all_words
);
   logic [WORDS*32-1:0] mem;

   // Storage and the registered read port share one process.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem <= '0;
         read_data <= 32'h0000_0000;
      end else begin
         if (write_enable) begin
            mem[write_index*32 +: 32] <= write_data;
         end
         read_data <= mem[read_index*32 +: 32];
      end
   end

   assign all_words = mem;
endmodule

// >>> tb/ptpse_core_monitor.sv
`timescale 1ns/1ps
// Watches the bus answers and the timing outputs of the servo core.
module ptpse_core_monitor
   import ptpse_pkg::*;
#(
   parameter int NS_PER_CYCLE = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic offset_valid,
   input wire logic [63:0] local_time,
   input wire logic periodic_event,
   input wire logic irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Writes of zero that should silence the generator or the interrupt.
   sequence stop_gen;
      psel && penable && pwrite && paddr == OFS_INTERVAL && pwdata == 32'h0;
   endsequence
   sequence mask_off;
      psel && penable && pwrite && paddr == OFS_IRQ_MASK && pwdata == 32'h0;
   endsequence
   sequence quiet_gap;
      !periodic_event [*8];
   endsequence
   chk_zero_wait: assert property (pready) else $error("pready low");
   // A reference load or an offset sample taken while synchronizing may step the count; nothing else may.
   chk_time_step: assert property ($past(presetn) && !$past(offset_valid) &&
      !$past(psel && penable && pwrite && paddr == OFS_REFTIME_HI)
      |-> local_time == $past(local_time) + NS_PER_CYCLE) else $error("local time step wrong");
   chk_err_unmapped: assert property (psel && penable && paddr > OFS_CORRECTION |-> pslverr) else $error("no error");
   chk_err_mapped: assert property (psel && penable && paddr <= OFS_CORRECTION && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("false error");
   chk_err_setup: assert property (!(psel && penable) |-> !pslverr) else $error("error outside access");
   chk_err_data: assert property (pslverr |-> prdata == 32'h0) else $error("error read data not zero");
   chk_event_pulse: assert property (periodic_event |=> !periodic_event) else $error("event too long");
   chk_gen_stop: assert property (stop_gen |=> ##1 quiet_gap) else $error("event after stop");
   chk_irq_masked: assert property (mask_off |=> !irq) else $error("irq while masked");
endmodule

bind ptpse_core ptpse_core_monitor #(.NS_PER_CYCLE(NS_PER_CYCLE)) mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .offset_valid(offset_valid), .local_time(local_time), .periodic_event(periodic_event),
   .irq(irq));

// >>> tb/ptpse_master_model.sv
`timescale 1ns/1ps
// Remote time master: hands over offset samples and port change events.
module ptpse_master_model #(
   parameter logic [47:0] HW_ADDRESS = 48'h02_0000_00a5,
   parameter logic [1:0] TRANSPORT = 2'h1
) (
   input wire logic pclk,
   output logic [47:0] master_hw_address,
   output logic offset_valid,
   output logic [63:0] master_offset_nanoseconds,
   output logic port_event_valid,
   output logic [3:0] port_event_code,
   output logic [1:0] time_message_transport
);
   // The address is arbitrary; the lines idle low until a sample arrives.
   initial begin
      master_hw_address = HW_ADDRESS;
      time_message_transport = TRANSPORT;
      offset_valid = 1'b0;
      master_offset_nanoseconds = 64'h0;
      port_event_valid = 1'b0;
      port_event_code = 4'h0;
   end
   // Stale data is inverted so a late capture cannot pass by luck.
   task automatic send_offset(input logic [63:0] v);
      @(posedge pclk);
      offset_valid <= 1'b1;
      master_offset_nanoseconds <= v;
      @(posedge pclk);
      offset_valid <= 1'b0;
      master_offset_nanoseconds <= ~v;
   endtask
   task automatic send_event(input logic [3:0] c);
      @(posedge pclk);
      port_event_valid <= 1'b1;
      port_event_code <= c;
      @(posedge pclk);
      port_event_valid <= 1'b0;
      port_event_code <= ~c;
   endtask
endmodule

// >>> tb/tb_ptpse_core.sv
`timescale 1ns/1ps
module tb_ptpse_core;
   import ptpse_pkg::*;
   localparam logic [47:0] MAC = 48'h12_3456_789abc;
   localparam logic [1:0] XPORT = 2'h2;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, clock_correction, rd;
   logic pready, pslverr, offset_valid, port_event_valid, periodic_event, irq, err;
   logic [47:0] master_hw_address;
   logic [63:0] master_offset_nanoseconds, local_time;
   logic [3:0] port_event_code;
   logic [1:0] time_message_transport;
   int mismatches = 0, samples_checked = 0, cycles = 0;
   always #2.5 pclk = ~pclk;
   ptpse_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .master_hw_address(master_hw_address), .offset_valid(offset_valid),
      .master_offset_nanoseconds(master_offset_nanoseconds), .port_event_valid(port_event_valid),
      .port_event_code(port_event_code), .time_message_transport(time_message_transport),
      .local_time(local_time), .clock_correction(clock_correction), .periodic_event(periodic_event), .irq(irq));
   ptpse_master_model #(.HW_ADDRESS(MAC), .TRANSPORT(XPORT)) m (.pclk(pclk), .master_hw_address(master_hw_address),
      .offset_valid(offset_valid), .master_offset_nanoseconds(master_offset_nanoseconds),
      .port_event_valid(port_event_valid), .port_event_code(port_event_code),
      .time_message_transport(time_message_transport));
   task automatic report_and_stop;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // A hung wait is cut off here and counted against the run.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask
   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check({32'h0, rd & msk}, {32'h0, e});
   endtask
   task automatic t_reset;
      rd_chk(OFS_CONTROL, 32'hffffffff, CTL_RESET);
      rd_chk(OFS_STATUS, 32'h3, {30'h0, servo_state_inapplicable});
      rd_chk(OFS_STATUS, 32'h300, {22'h0, XPORT, 8'h0});
      rd_chk(OFS_IDENT_LO, 32'hffffffff, {IDENT_FILL[7:0], MAC[23:0]});
      rd_chk(OFS_IDENT_HI, 32'hffffffff, {MAC[47:24], IDENT_FILL[15:8]});
      apb(1'b0, 8'h80, 32'h0);
      check({31'h0, err, rd}, {31'h0, 1'b1, 32'h0});
   endtask
   // Each step limit is probed exactly at its edge and one nanosecond past it.
   task automatic t_servo;
      int lim[6];
      logic [63:0] v;
      lim = '{LIMIT_US_0, LIMIT_US_1, LIMIT_US_2, LIMIT_US_3, LIMIT_US_4, LIMIT_US_5};
      apb(1'b1, OFS_IRQ_MASK, 32'h0);
      apb(1'b1, OFS_CONTROL, 32'h10);
      rd_chk(OFS_STATUS, 32'h3, {30'h0, SERVO_NOT_READY});
      for (int i = 0; i < 6; i++) begin
         v = 64'(lim[i]) * 64'd1000;
         apb(1'b1, OFS_CONTROL, 32'h10 | i);
         m.send_offset(v);
         rd_chk(OFS_STATUS, 32'h3, {30'h0, SERVO_LOCKED});
         m.send_offset(v + 64'd1);
         rd_chk(OFS_STATUS, 32'h3, {30'h0, SERVO_SYNCHRONIZING});
         rd_chk(OFS_IRQ_STATUS, 32'h1, 32'h1);
         check({63'h0, irq}, 64'h0);
         apb(1'b1, OFS_IRQ_STATUS, 32'hf);
         rd_chk(OFS_IRQ_STATUS, 32'h1, 32'h0);
      end
      v = -64'sd2000000;
      m.send_offset(v);
      rd_chk(OFS_STATUS, 32'h3, {30'h0, SERVO_LOCKED});
      rd_chk(OFS_OFFSET_LO, 32'hffffffff, v[31:0]);
      rd_chk(OFS_OFFSET_HI, 32'hffffffff, v[63:32]);
      check({32'h0, clock_correction}, {32'h0, v[31:0]});
      m.send_offset(v - 64'd1);
      rd_chk(OFS_STATUS, 32'h3, {30'h0, SERVO_SYNCHRONIZING});
   endtask
   task automatic t_events;
      apb(1'b1, OFS_IRQ_STATUS, 32'hf);
      apb(1'b1, OFS_IRQ_MASK, 32'h1 << IRQ_PORT_EVENT_BIT);
      for (int c = 0; c < 16; c++) begin
         m.send_event(4'(c));
         rd_chk(OFS_EVENT, 32'hf, 32'(c));
         check({63'h0, irq}, 64'h1);
         apb(1'b1, OFS_IRQ_STATUS, 32'h8);
         @(posedge pclk);
         check({63'h0, irq}, 64'h0);
      end
   endtask
   task automatic wait_pulse;
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (periodic_event !== 1'b1 && k < 2000);
      check({63'h0, periodic_event}, 64'h1);
   endtask
   // Begin time sits ahead of now, so the start gate must hold the first event.
   task automatic t_periodic;
      logic [63:0] b, t1;
      int n;
      apb(1'b0, OFS_TIME_LO, 32'h0);
      b[31:0] = rd;
      apb(1'b0, OFS_TIME_HI, 32'h0);
      b = {rd, b[31:0]} + 64'd1000;
      apb(1'b1, OFS_BEGIN_LO, b[31:0]);
      apb(1'b1, OFS_BEGIN_HI, b[63:32]);
      apb(1'b1, OFS_INTERVAL, 32'h4);
      wait_pulse();
      t1 = local_time;
      check({63'h0, t1 > b}, 64'h1);
      check({63'h0, t1 - b + 80 >= 128 && t1 - b <= 128 + 85}, 64'h1);
      wait_pulse();
      check({63'h0, local_time - t1 + 80 >= 128 && local_time - t1 <= 208}, 64'h1);
      apb(1'b1, OFS_INTERVAL, 32'h0);
      repeat (3) @(posedge pclk);
      n = 0;
      repeat (200) @(posedge pclk) n += int'(periodic_event);
      check(64'(n), 64'h0);
   endtask
   task automatic t_ref;
      apb(1'b1, OFS_REFTIME_LO, 32'h1000_0000);
      apb(1'b1, OFS_REFTIME_HI, 32'h2);
      @(posedge pclk);
      check({63'h0, local_time - 64'h2_1000_0000 > 64'd20}, 64'h1);
      apb(1'b1, OFS_CONTROL, 32'h30);
      apb(1'b1, OFS_REFTIME_HI, 32'h2);
      @(posedge pclk);
      check({63'h0, local_time - 64'h2_1000_0000 <= 20}, 64'h1);
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_servo();
      t_events();
      t_periodic();
      t_ref();
      report_and_stop();
   end
endmodule
